// file: bench/rcm_ref_src.sv
// oscillator and two reference sources beyond the pins
// assumes the bench starts and stops each reference through run0 and run1
`timescale 1ns/1ps
module rcm_ref_src (
  input wire logic run0,
  input wire logic run1,
  output logic osc,
  output logic ref0,
  output logic ref1
);
  // a stopped reference sticks at its last level, as a dead source does
  initial osc = 1'b0;
  initial ref0 = 1'b0;
  initial ref1 = 1'b1;
  always #110 osc = ~osc;
  always #90 if (run0) ref0 = ~ref0;
  always #70 if (run1) ref1 = ~ref1;
endmodule

// file: bench/rcm_switchover_checker.sv
// pin-level assertions for the switchover block
// assumes it is bound onto rcm_switchover and sees only its ports
`timescale 1ns/1ps
module rcm_switchover_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fb_clk,
  input wire logic pd_ref_clk,
  input wire logic ref_ack,
  input wire logic ref_loss_flag
);
  logic fb_q, fb_q2, pd_q, ack_q, seen, auto_done;
  logic [1:0] miss;
  logic [3:0] ack_age, wr_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    fb_q <= fb_clk;
    fb_q2 <= fb_q;
    pd_q <= pd_ref_clk;
    ack_q <= ref_ack;
  end
  // missed feedback edges of the routed reference, rebuilt from the pins
  // feedback is looked at one cycle late: pd_ref_clk lags its monitor by one more flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
      miss <= 2'h0;
    end else if (fb_q != fb_q2) begin
      seen <= 1'b0;
      miss <= (seen || pd_ref_clk != pd_q) ? 2'h0 : (miss == 2'h3 ? miss : miss + 2'h1);
    end else if (pd_ref_clk != pd_q) begin
      seen <= 1'b1;
    end
  end
  // a fresh reselection makes the loss pin jump, so wait for it to settle
  always_ff @(posedge aclk) begin
    if (!aresetn || ref_ack != ack_q) ack_age <= 4'h0;
    else if (ack_age != 4'hf) ack_age <= ack_age + 4'h1;
  end
  // a register write explains an ack change for a few cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_cnt <= 4'h0;
    else if (s_axi_wvalid && s_axi_wready) wr_cnt <= 4'h8;
    else if (wr_cnt != 4'h0) wr_cnt <= wr_cnt - 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready)) auto_done <= 1'b0;
    else if (ref_ack != ack_q && wr_cnt == 4'h0) auto_done <= 1'b1;
  end
  loss_rise_a: assert property ($rose(ref_loss_flag) && ack_age == 4'hf
    && ref_ack == ack_q |=> miss == 2'h3) else $error("loss rose without missed feedback edges");
  loss_fall_a: assert property ($fell(ref_loss_flag) && ack_age == 4'hf
    && ref_ack == ack_q |=> miss == 2'h0) else $error("loss fell without a reference edge");
  no_revert_a: assert property ($changed(ref_ack) |-> !auto_done || wr_cnt != 4'h0)
    else $error("second automatic reselection");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  b_delay_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  r_delay_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  cover property ($rose(auto_done));
  cover property ($rose(ref_loss_flag));
  cover property (s_axi_bvalid && s_axi_bresp == rcm_pkg::RESP_SLVERR);
endmodule

bind rcm_switchover rcm_switchover_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fb_clk(fb_clk),
  .pd_ref_clk(pd_ref_clk), .ref_ack(ref_ack), .ref_loss_flag(ref_loss_flag)
);

// file: bench/ref_clock_monitor_switchover_tb_top.sv
// self-checking bench: a mode/select model against the pins and status
// assumes rcm_switchover, its checker and rcm_ref_src are compiled first
`timescale 1ns/1ps
module ref_clock_monitor_switchover_tb_top;
  logic aclk, aresetn, osc, ref0, ref1, run0, run1, fb_clk, pd_ref_clk, ref_ack, ref_loss_flag;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int failures, n_checks, m_sel, m_st;

  rcm_ref_src src (.run0(run0), .run1(run1), .osc(osc), .ref0(ref0), .ref1(ref1));
  rcm_switchover dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .vcso_clk_in(osc),
    .ref_input_zero_p(ref0), .ref_input_one_p(ref1), .fb_clk(fb_clk),
    .pd_ref_clk(pd_ref_clk), .ref_ack(ref_ack), .ref_loss_flag(ref_loss_flag));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic report_and_stop();
    if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    q = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // model: 0 manual, 1 armed, 2 switched
  task automatic set_ctrl(input logic [31:0] v);
    axi_write(rcm_pkg::ROFF_CTRL, v, r);
    chk(32'(r), 32'(rcm_pkg::RESP_OKAY));
    if (!v[0]) begin
      m_st = 0;
      m_sel = int'(v[1]);
    end else if (m_st == 0) begin
      m_st = 1;
      m_sel = int'(v[1]);
    end
  endtask

  task automatic check_pins();
    logic lost, fb_prev, pd_prev;
    int fb_n, pd_n;
    fb_n = 0;
    pd_n = 0;
    fb_prev = fb_clk;
    pd_prev = pd_ref_clk;
    for (int i = 0; i < 80; i++) begin
      @(posedge aclk);
      if (fb_clk !== fb_prev) fb_n++;
      if (i >= 40 && pd_ref_clk !== pd_prev) pd_n++;
      fb_prev = fb_clk;
      pd_prev = pd_ref_clk;
    end
    if (m_st == 1 && !(m_sel == 1 ? run1 : run0)) begin
      m_sel = 1 - m_sel;
      m_st = 2;
    end
    lost = !(m_sel == 1 ? run1 : run0);
    axi_read(rcm_pkg::ROFF_STATUS, d, r);
    chk(32'(ref_ack), 32'(m_sel));
    chk(32'(ref_loss_flag), 32'(lost));
    chk(32'(d[1:0]), 32'({lost, m_sel[0]}));
    chk(32'(d[3:2]), 32'({!run1, !run0}));
    chk(32'(d[5:4]), 32'(m_st));
    chk(32'(d[6]), 32'h0);
    // osc edge every 110 ns, fb_div 2: about 14.5 feedback toggles in 3200 ns
    chk(32'(fb_n >= 13 && fb_n <= 16), 32'h1);
    chk(32'(pd_n != 0), 32'(!lost));
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    {failures, n_checks, m_sel, m_st} = {32'h0, 32'h0, 32'h0, 32'h0};
    {run0, run1, aresetn} = 3'b110;
    void'($urandom(32'h72af));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(rcm_pkg::ROFF_CTRL, d, r);
    chk(d, 32'(rcm_pkg::CTRL_RST));
    axi_read(rcm_pkg::ROFF_FBDIV, d, r);
    chk(d, 32'(rcm_pkg::FBDIV_RST));
    axi_write(rcm_pkg::ROFF_FBDIV, 32'h2, r);
    axi_read(rcm_pkg::ROFF_FBDIV, d, r);
    chk(d, 32'h2);
    axi_write(8'h0c, 32'h1, r);
    chk(32'(r), 32'(rcm_pkg::RESP_SLVERR));
    axi_read(8'h0c, d, r);
    chk({d[29:0], r}, 32'(rcm_pkg::RESP_SLVERR));
    axi_write(rcm_pkg::ROFF_STATUS, 32'hff, r);
    chk(32'(r), 32'(rcm_pkg::RESP_OKAY));
    check_pins();
    repeat (4) begin
      set_ctrl($urandom & 32'h2);
      check_pins();
    end
    set_ctrl(32'h0);
    run0 <= 1'b0;
    check_pins();
    run0 <= 1'b1;
    check_pins();
    set_ctrl(32'h1);
    run1 <= 1'b0;
    check_pins();
    run0 <= 1'b0;
    check_pins();
    check_pins();
    set_ctrl(32'h1);
    check_pins();
    run0 <= 1'b1;
    run1 <= 1'b1;
    check_pins();
    set_ctrl(32'h3);
    set_ctrl(32'h2);
    set_ctrl(32'h3);
    run1 <= 1'b0;
    check_pins();
    run1 <= 1'b1;
    set_ctrl(32'h4);
    set_ctrl(32'h6);
    check_pins();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    report_and_stop();
  end
endmodule

// file: rtl/rcm_activity_monitor.sv
// activity monitor for one reference input
// assumes ref_pin is asynchronous and fb_edge is a one-cycle aclk pulse
`timescale 1ns/1ps
module rcm_activity_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ref_pin,
  input wire logic fb_edge,
  output logic ref_edge,
  output logic ref_level,
  output logic loss
);
  logic [2:0] sync;
  logic seen;
  logic [1:0] miss;
  logic [1:0] next_miss;

  // samplers run through reset so the filtered level starts at the pin level
  always_ff @(posedge aclk) begin
    sync <= {sync[1:0], ref_pin};
  end

  // a change only counts once the second and third stages agree
  // loading the pin level in reset avoids a false edge just after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_level <= sync[2];
    end else if (sync[1] == sync[2]) begin
      ref_level <= sync[2];
    end
  end

  // both transitions are edges
  assign ref_edge = (sync[1] == sync[2]) && (sync[2] != ref_level);

  // an edge landing on the feedback edge is folded in, never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen <= 1'b0;
    end else if (fb_edge) begin
      seen <= 1'b0;
    end else if (ref_edge) begin
      seen <= 1'b1;
    end
  end

  // only presence of edges matters, so many edges are as good as one
  always_comb begin
    next_miss = miss;
    if (seen || ref_edge) begin
      next_miss = 2'h0;
    end else if (miss != rcm_pkg::LOSS_EDGES) begin
      next_miss = miss + 2'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miss <= 2'h0;
      loss <= 1'b0;
    end else if (fb_edge) begin
      miss <= next_miss;
      loss <= (next_miss == rcm_pkg::LOSS_EDGES);
    end
  end
endmodule

// file: rtl/rcm_pkg.sv
// constants shared by the reference clock monitor and switchover block
// assumes a single aclk domain; all pins are sampled by the block itself
package rcm_pkg;
  // register byte offsets (one aligned 32-bit word each)
  localparam logic [7:0] ROFF_CTRL = 8'h00;
  localparam logic [7:0] ROFF_STATUS = 8'h04;
  localparam logic [7:0] ROFF_FBDIV = 8'h08;
  // control register fields
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_PBO_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // status register fields
  localparam int ST_ACK_BIT = 0;
  localparam int ST_LOSS_BIT = 1;
  localparam int ST_LOSS0_BIT = 2;
  localparam int ST_LOSS1_BIT = 3;
  localparam int ST_ARMED_BIT = 4;
  localparam int ST_SWITCHED_BIT = 5;
  localparam int ST_PBO_PEND_BIT = 6;
  // feedback divider reset value
  localparam logic [15:0] FBDIV_RST = 16'h0008;
  // missing feedback edges that declare a reference lost
  localparam logic [1:0] LOSS_EDGES = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register select codes
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_STATUS = 2'h1;
  localparam logic [1:0] SEL_FBDIV = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;
  // switchover states
  typedef enum logic [2:0] {
    ST_MANUAL = 3'h1,
    ST_ARMED = 3'h2,
    ST_SWITCHED = 3'h4
  } rcm_state_t;
endpackage

// file: rtl/rcm_switchover.sv
// reference clock supervision, selection mux and feedback divider
// assumes one aclk domain; oscillator and reference pins are asynchronous
// assumes an axi4-lite master that keeps one read and one write in flight
//
// Operation
// - each input monitored; selected result drives loss
// - monitors run on the feedback clock
// - feedback clock is oscillator over divider
// - loss after three feedback edges without reference
// - rising and falling transitions both count
// - only presence of transitions matters
// - acknowledge shows index of routed reference
// - armed and loss: switch to other input
// - one reselection per arming, never revert
// - rearm needs mode low then high
// - manual select chooses; value at arming kept
// - after switch, manual select is ignored
// - switch to dead input: ack toggles, loss high
// - build-out triggered only by mux change
// - build-out realigns feedback edge to new reference
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module rcm_switchover #(
  parameter int ADDR_W = 8,
  parameter int DIV_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic vcso_clk_in,
  input wire logic ref_input_zero_p,
  input wire logic ref_input_one_p,
  output logic fb_clk,
  output logic pd_ref_clk,
  output logic ref_ack,
  output logic ref_loss_flag
);
  if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
    $error("rcm_switchover: ADDR_W must be 4 to 32");
  end
  if (DIV_W < 2 || DIV_W > 16) begin : g_bad_div
    $error("rcm_switchover: DIV_W must be 2 to 16");
  end

  // register decode, shared by the write and read paths
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = rcm_pkg::SEL_NONE;
    if (a == ADDR_W'(rcm_pkg::ROFF_CTRL)) begin
      s = rcm_pkg::SEL_CTRL;
    end else if (a == ADDR_W'(rcm_pkg::ROFF_STATUS)) begin
      s = rcm_pkg::SEL_STATUS;
    end else if (a == ADDR_W'(rcm_pkg::ROFF_FBDIV)) begin
      s = rcm_pkg::SEL_FBDIV;
    end
    return s;
  endfunction

  // software-visible control
  logic auto_mode;
  logic manual_sel;
  logic pbo_en;
  logic [DIV_W-1:0] fb_div;

  // write channel holding
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [1:0] wsel;

  // oscillator sampling and feedback divider
  logic [2:0] osc_sync;
  logic osc_level;
  logic osc_edge;
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] div_lim;
  logic fb_edge;

  // monitors and selection
  logic edge0;
  logic edge1;
  logic level0;
  logic level1;
  logic loss0;
  logic loss1;
  logic sel_loss;
  logic sel_edge;
  logic sel;
  logic sel_d;
  logic pbo_pending;
  logic pbo_align;
  rcm_pkg::rcm_state_t state;
  logic [31:0] status_word;

  // ---------------- axi4-lite write path ----------------
  assign wsel = reg_sel(aw_addr);
  assign do_write = aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rcm_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wsel == rcm_pkg::SEL_NONE) ? rcm_pkg::RESP_SLVERR : rcm_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      auto_mode <= rcm_pkg::CTRL_RST[rcm_pkg::CTRL_AUTO_BIT];
      manual_sel <= rcm_pkg::CTRL_RST[rcm_pkg::CTRL_SEL_BIT];
      pbo_en <= rcm_pkg::CTRL_RST[rcm_pkg::CTRL_PBO_BIT];
    end else if (do_write && wsel == rcm_pkg::SEL_CTRL && w_strb[0]) begin
      auto_mode <= w_data[rcm_pkg::CTRL_AUTO_BIT];
      manual_sel <= w_data[rcm_pkg::CTRL_SEL_BIT];
      pbo_en <= w_data[rcm_pkg::CTRL_PBO_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_div <= DIV_W'(rcm_pkg::FBDIV_RST);
    end else if (do_write && wsel == rcm_pkg::SEL_FBDIV) begin
      // per-bit lanes avoid a reversed slice when DIV_W is 8
      for (int i = 0; i < DIV_W; i++) begin
        if (w_strb[i / 8]) begin
          fb_div[i] <= w_data[i];
        end
      end
    end
  end

  // ---------------- axi4-lite read path ----------------
  always_comb begin
    status_word = 32'h0;
    status_word[rcm_pkg::ST_ACK_BIT] = ref_ack;
    status_word[rcm_pkg::ST_LOSS_BIT] = ref_loss_flag;
    status_word[rcm_pkg::ST_LOSS0_BIT] = loss0;
    status_word[rcm_pkg::ST_LOSS1_BIT] = loss1;
    status_word[rcm_pkg::ST_ARMED_BIT] = (state == rcm_pkg::ST_ARMED);
    status_word[rcm_pkg::ST_SWITCHED_BIT] = (state == rcm_pkg::ST_SWITCHED);
    status_word[rcm_pkg::ST_PBO_PEND_BIT] = pbo_pending;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= rcm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= rcm_pkg::RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        rcm_pkg::SEL_CTRL: begin
          s_axi_rdata <= 32'({pbo_en, manual_sel, auto_mode});
        end
        rcm_pkg::SEL_STATUS: begin
          s_axi_rdata <= status_word;
        end
        rcm_pkg::SEL_FBDIV: begin
          s_axi_rdata <= 32'(fb_div);
        end
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= rcm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ---------------- oscillator and feedback divider ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], vcso_clk_in};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_level <= 1'b0;
    end else if (osc_sync[1] == osc_sync[2]) begin
      osc_level <= osc_sync[2];
    end
  end

  assign osc_edge = (osc_sync[1] == osc_sync[2]) && (osc_sync[2] != osc_level);
  // a zero divider would never toggle, so it runs as divide by one
  assign div_lim = (fb_div == '0) ? '0 : fb_div - DIV_W'(1);
  // feedback toggles every fb_div oscillator edges: one period per fb_div cycles
  assign fb_edge = osc_edge && (div_cnt >= div_lim);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt <= '0;
    end else if (pbo_align) begin
      div_cnt <= div_lim;
    end else if (osc_edge) begin
      div_cnt <= fb_edge ? '0 : div_cnt + DIV_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fb_clk <= 1'b0;
    end else if (fb_edge) begin
      fb_clk <= ~fb_clk;
    end
  end

  // ---------------- activity monitors ----------------
  rcm_activity_monitor u_mon0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_pin(ref_input_zero_p),
    .fb_edge(fb_edge),
    .ref_edge(edge0),
    .ref_level(level0),
    .loss(loss0)
  );

  rcm_activity_monitor u_mon1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .ref_pin(ref_input_one_p),
    .fb_edge(fb_edge),
    .ref_edge(edge1),
    .ref_level(level1),
    .loss(loss1)
  );

  assign sel_loss = sel ? loss1 : loss0;
  assign sel_edge = sel ? edge1 : edge0;

  // ---------------- switchover state machine ----------------
  // a switch to a dead input still happens; its own monitor then keeps loss up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= rcm_pkg::ST_MANUAL;
      sel <= 1'b0;
    end else begin
      case (state)
        rcm_pkg::ST_MANUAL: begin
          sel <= manual_sel;
          if (auto_mode) begin
            state <= rcm_pkg::ST_ARMED;
          end
        end
        rcm_pkg::ST_ARMED: begin
          if (!auto_mode) begin
            state <= rcm_pkg::ST_MANUAL;
          end else if (sel_loss) begin
            sel <= ~sel;
            state <= rcm_pkg::ST_SWITCHED;
          end
        end
        rcm_pkg::ST_SWITCHED: begin
          // manual select and later losses have no effect here
          if (!auto_mode) begin
            state <= rcm_pkg::ST_MANUAL;
          end
        end
        default: begin
          state <= rcm_pkg::ST_MANUAL;
          sel <= 1'b0;
        end
      endcase
    end
  end

  // ---------------- phase build-out ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_d <= 1'b0;
    end else begin
      sel_d <= sel;
    end
  end

  // waits for the first edge of the new reference, the nearest phase point
  assign pbo_align = pbo_pending && sel_edge;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pbo_pending <= 1'b0;
    end else if (pbo_en && (sel != sel_d)) begin
      pbo_pending <= 1'b1;
    end else if (pbo_align || !pbo_en) begin
      pbo_pending <= 1'b0;
    end
  end

  // ---------------- outputs ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_ack <= 1'b0;
      ref_loss_flag <= 1'b0;
      pd_ref_clk <= 1'b0;
    end else begin
      ref_ack <= sel;
      ref_loss_flag <= sel_loss;
      pd_ref_clk <= sel ? level1 : level0;
    end
  end
endmodule
